// ### hdl/eeprom_slave_pkg.sv
// shared constants, types and states for the two-wire memory slave
package eeprom_slave_pkg;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned LOC_W        = 8;
    localparam int unsigned MEM_DEPTH    = 256;
    localparam int unsigned PAGE_BYTES   = 8;
    localparam int unsigned PAGE_IDX_W   = 3;
    localparam int unsigned BIT_CNT_W    = 4;
    localparam int unsigned FILT_W       = 2;
    localparam int unsigned DEV_ADDR_W   = 7;

    localparam logic [BIT_CNT_W-1:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [BIT_CNT_W-1:0]  BIT_CNT_RST   = 4'h0;
    localparam logic [FILT_W-1:0]     FILT_STABLE   = 2'h3;
    localparam logic [LOC_W-1:0]      LOC_RST       = 8'h00;
    localparam logic [PAGE_BYTES-1:0] MASK_NONE     = 8'h00;
    // slave address: arbitrary neutral value
    localparam logic [DEV_ADDR_W-1:0] DEV_ADDR_DEFAULT = 7'h2a;

    // system clock and self-timed commit duration
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned INTERNAL_PROGRAM_TIME_NS = 5000000;
    localparam int unsigned PROG_CYCLES_DEFAULT =
        (INTERNAL_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROG_CNT_W = 24;

    // which byte of the frame is being received
    typedef enum logic [1:0] {
        PH_DEV  = 2'h0,
        PH_LOC  = 2'h1,
        PH_DATA = 2'h3
    } phase_t;

    // gray codes along idle -> receive -> ack -> send -> master ack
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX   = 3'h1,
        ST_ACK  = 3'h3,
        ST_TX   = 3'h2,
        ST_MACK = 3'h6
    } state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_in_t;

    typedef struct packed {
        logic prog_busy;
        logic selected;
        logic read_mode;
    } status_t;
endpackage

// ### hdl/eeprom_slave.sv
// two-wire slave front end with page buffer, timed commit and memory array
// Overview of operation
// [R1] write address with no protection enters write mode
// [R2] ack location byte by pulling data low
// [R3] ack each data byte for one clock
// [R4] stop starts timed commit, bus ignored meanwhile
// [R5] no address ack while commit runs
// [R6] page writes up to eight aligned bytes
// [R7] master may stream up to seven more bytes
// [R8] commit only after stop, otherwise discard
// [R9] write pointer wraps inside its page
// [R10] ninth byte onward overwrites earlier page bytes
// [R11] read address enters read mode
// [R12] pointer is last location plus one, wraps
// [R13] current read sends byte at pointer
// [R14] random read: write header then restart
// [R15] master ack requests next byte, wraps to zero
// [R16] master nack then stop ends read
// [R17] master starts only on idle bus
// [R18] data change with clock high is control
// [R19] start is data falling with clock high
// [R20] stop is data rising with clock high
// [R21] slave only, open-drain, master clocks
// [R22] ack address and data on ninth clock
// [R23] address mismatch: no ack, back to idle
// [R24] lines synchronised and filtered before detection
// [R25] protected write leaves memory, no commit
`timescale 1ns/1ps
module eeprom_slave
    import eeprom_slave_pkg::*;
#(
    parameter logic [DEV_ADDR_W-1:0] DEV_ADDR    = DEV_ADDR_DEFAULT,
    parameter int unsigned           PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire eeprom_slave_pkg::bus_in_t  bus_in,
    input  wire logic                       write_protect,
    output logic                            sda_o,
    output logic                            sda_oe,
    output eeprom_slave_pkg::status_t       status
);
    import eeprom_slave_pkg::*;

    logic [1:0]                  scl_sync_q;
    logic [1:0]                  sda_sync_q;
    logic                        wp_meta_q;
    logic                        wp_q;
    logic [FILT_W-1:0]           scl_cnt_q;
    logic [FILT_W-1:0]           sda_cnt_q;
    logic                        scl_q;
    logic                        sda_q;
    logic                        scl_prev_q;
    logic                        sda_prev_q;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_det;
    logic                        stop_det;

    state_t                      state_q;
    phase_t                      phase_q;
    logic [BIT_CNT_W-1:0]        bit_cnt_q;
    logic [DATA_W-1:0]           shift_q;
    logic                        read_q;
    logic                        master_ack_q;
    logic [LOC_W-1:0]            ptr_q;
    logic                        sda_oe_q;

    logic [DATA_W-1:0]           mem [MEM_DEPTH];
    logic [DATA_W-1:0]           page_buf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0]       page_valid_q;
    logic [LOC_W-PAGE_IDX_W-1:0] page_base_q;
    logic                        prog_busy_q;
    logic [PROG_CNT_W-1:0]       prog_cnt_q;

    logic [DATA_W-1:0]           rx_byte;
    logic                        byte_done;
    logic                        addr_match;

    localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES - 1);

    // increment the low location bits only, staying in the page
    function automatic logic [LOC_W-1:0] page_next(input logic [LOC_W-1:0] loc);
        page_next = {loc[LOC_W-1:PAGE_IDX_W], loc[PAGE_IDX_W-1:0] + PAGE_IDX_W'(1)};
    endfunction

    // count-up filter: a line level is taken only once it stays put
    function automatic logic [FILT_W-1:0] filt_cnt(input logic raw, input logic cur,
                                                    input logic [FILT_W-1:0] cnt);
        if (raw == cur) begin
            filt_cnt = BIT_CNT_RST[FILT_W-1:0];
        end else if (cnt != FILT_STABLE) begin
            filt_cnt = cnt + FILT_W'(1);
        end else begin
            filt_cnt = BIT_CNT_RST[FILT_W-1:0];
        end
    endfunction

    // two-stage synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            wp_meta_q  <= 1'b0;
            wp_q       <= 1'b0;
        end else if (ce) begin
            scl_sync_q <= {scl_sync_q[0], bus_in.scl}; // R24
            sda_sync_q <= {sda_sync_q[0], bus_in.sda}; // R24
            wp_meta_q  <= write_protect;
            wp_q       <= wp_meta_q;
        end
    end

    // glitch filter, then edge history
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_cnt_q  <= BIT_CNT_RST[FILT_W-1:0];
            sda_cnt_q  <= BIT_CNT_RST[FILT_W-1:0];
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce) begin
            scl_cnt_q  <= filt_cnt(scl_sync_q[1], scl_q, scl_cnt_q); // R24
            sda_cnt_q  <= filt_cnt(sda_sync_q[1], sda_q, sda_cnt_q); // R24
            if (scl_sync_q[1] != scl_q && scl_cnt_q == FILT_STABLE) begin
                scl_q <= scl_sync_q[1];
            end
            if (sda_sync_q[1] != sda_q && sda_cnt_q == FILT_STABLE) begin
                sda_q <= sda_sync_q[1];
            end
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    assign scl_rise  = scl_q && !scl_prev_q;
    assign scl_fall  = !scl_q && scl_prev_q;
    // data moving under a high clock is framing, never data
    assign start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q; // R18 R19
    assign stop_det  = scl_q && scl_prev_q && !sda_prev_q && sda_q; // R18 R20
    assign rx_byte   = shift_q;
    assign byte_done = (bit_cnt_q == BITS_PER_BYTE);
    // polling during a commit sees no ack
    assign addr_match = (rx_byte[DATA_W-1:1] == DEV_ADDR) && !prog_busy_q; // R5 R23

    // bus protocol engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q      <= ST_IDLE;
            phase_q      <= PH_DEV;
            bit_cnt_q    <= BIT_CNT_RST;
            shift_q      <= '0;
            read_q       <= 1'b0;
            master_ack_q <= 1'b0;
            sda_oe_q     <= 1'b0;
        end else if (ce) begin
            if (stop_det) begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (start_det) begin
                state_q   <= ST_RX;
                phase_q   <= PH_DEV;
                bit_cnt_q <= BIT_CNT_RST;
                sda_oe_q  <= 1'b0;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        sda_oe_q <= 1'b0;
                    end
                    ST_RX: begin
                        if (scl_rise && !byte_done) begin
                            shift_q   <= {shift_q[DATA_W-2:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
                        end else if (scl_fall && byte_done) begin
                            if (phase_q != PH_DEV || addr_match) begin
                                state_q  <= ST_ACK;
                                sda_oe_q <= 1'b1; // R2 R3 R22
                                if (phase_q == PH_DEV) begin
                                    read_q <= rx_byte[0]; // R1 R11
                                end
                            end else begin
                                state_q <= ST_IDLE; // R23
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= BIT_CNT_RST;
                            if (phase_q == PH_DEV && read_q) begin
                                state_q  <= ST_TX; // R13
                                shift_q  <= mem[ptr_q];
                                sda_oe_q <= !mem[ptr_q][DATA_W-1];
                            end else begin
                                state_q  <= ST_RX;
                                sda_oe_q <= 1'b0;
                                phase_q  <= (phase_q == PH_DEV) ? PH_LOC : PH_DATA;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_q == BITS_PER_BYTE - BIT_CNT_W'(1)) begin
                                state_q  <= ST_MACK;
                                sda_oe_q <= 1'b0;
                            end else begin
                                shift_q   <= {shift_q[DATA_W-2:0], 1'b0};
                                sda_oe_q  <= !shift_q[DATA_W-2];
                                bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            master_ack_q <= !sda_q;
                        end else if (scl_fall) begin
                            bit_cnt_q <= BIT_CNT_RST;
                            if (master_ack_q) begin
                                state_q  <= ST_TX; // R15
                                shift_q  <= mem[ptr_q];
                                sda_oe_q <= !mem[ptr_q][DATA_W-1];
                            end else begin
                                state_q <= ST_IDLE; // R16
                            end
                        end
                    end
                    default: begin
                        state_q  <= ST_IDLE;
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // address pointer: loaded by the location byte, advanced per byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_q <= LOC_RST;
        end else if (ce && !start_det && !stop_det && scl_fall) begin
            if (state_q == ST_RX && byte_done && phase_q == PH_LOC) begin
                ptr_q <= rx_byte; // R14
            end else if (state_q == ST_RX && byte_done && phase_q == PH_DATA && !read_q) begin
                ptr_q <= page_next(ptr_q); // R9
            end else if ((state_q == ST_ACK && phase_q == PH_DEV && read_q) ||
                         (state_q == ST_MACK && master_ack_q)) begin
                ptr_q <= ptr_q + LOC_W'(1); // R12 R15
            end
        end
    end

    // page buffer: bytes land by low location bits, later ones overwrite
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            page_valid_q <= MASK_NONE;
            page_base_q  <= '0;
        end else if (ce) begin
            if (start_det && state_q != ST_IDLE) begin
                page_valid_q <= MASK_NONE; // R8
            end else if (stop_det) begin
                page_valid_q <= MASK_NONE;
            end else if (scl_fall && state_q == ST_RX && byte_done) begin
                if (phase_q == PH_LOC) begin
                    page_base_q <= rx_byte[LOC_W-1:PAGE_IDX_W]; // R6
                end else if (phase_q == PH_DATA && !wp_q) begin
                    page_buf_q[ptr_q[PAGE_IDX_W-1:0]]   <= rx_byte; // R7 R10
                    page_valid_q[ptr_q[PAGE_IDX_W-1:0]] <= 1'b1;
                end
            end
        end
    end

    // self-timed commit: only a stop after buffered data starts it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prog_busy_q <= 1'b0;
            prog_cnt_q  <= '0;
        end else if (ce) begin
            if (prog_busy_q) begin
                if (prog_cnt_q == PROG_LAST) begin
                    prog_busy_q <= 1'b0;
                end else begin
                    prog_cnt_q <= prog_cnt_q + PROG_CNT_W'(1);
                end
            end else if (stop_det && page_valid_q != MASK_NONE && !wp_q) begin
                prog_busy_q <= 1'b1; // R4 R8 R25
                prog_cnt_q  <= '0;
            end
        end
    end

    // array is written at the stop, but reads are refused until the timer ends
    always_ff @(posedge clk) begin
        if (ce && !prog_busy_q && stop_det && !wp_q) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (page_valid_q[i]) begin
                    mem[{page_base_q, PAGE_IDX_W'(i)}] <= page_buf_q[i]; // R8 R25
                end
            end
        end
    end

    // open drain: the pin is only ever pulled low
    assign sda_o  = 1'b0; // R21
    assign sda_oe = sda_oe_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= '0;
        end else if (ce) begin
            status.prog_busy <= prog_busy_q;
            status.selected  <= (state_q != ST_IDLE) && !(state_q == ST_RX && phase_q == PH_DEV);
            status.read_mode <= read_q;
        end
    end
endmodule

// ### test/eeprom_slave_sva.sv
// concurrent checks on the two-wire memory slave ports
`timescale 1ns/1ps
module eeprom_slave_sva
    import eeprom_slave_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire eeprom_slave_pkg::bus_in_t bus_in,
    input wire logic                      write_protect,
    input wire logic                      sda_o,
    input wire logic                      sda_oe,
    input wire eeprom_slave_pkg::status_t status
);
    int busy_cnt_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // commit length so far, cleared whenever the commit is not running
    always_ff @(posedge clk) begin
        if (!rst_n || !status.prog_busy) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 1;
        end
    end
    chk_odrain_low: assert property (sda_o == 1'b0)
        else $error("data output value not low");
    chk_busy_no_drive: assert property (status.prog_busy |-> !sda_oe)
        else $error("data driven during commit");
    chk_commit_length: assert property ($fell(status.prog_busy) |-> busy_cnt_q == PROG_CYCLES)
        else $error("commit length wrong");
    chk_commit_on_stop: assert property ($rose(status.prog_busy) |-> bus_in.scl && bus_in.sda && !write_protect)
        else $error("commit without stop or while protected");
    chk_drive_scl_low: assert property ($changed(sda_oe) |-> !bus_in.scl)
        else $error("data drive changed with clock high");
    chk_ack_held: assert property ($rose(sda_oe) |-> sda_oe[*8])
        else $error("drive too short");
    chk_commit_gap: assert property ($fell(status.prog_busy) |-> !status.prog_busy[*8])
        else $error("commit restarted at once");
    chk_select_idle: assert property ($rose(status.selected) |-> !status.prog_busy)
        else $error("selected during commit");
endmodule

bind eeprom_slave eeprom_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) i_eeprom_slave_sva (
    .clk(clk),
    .rst_n(rst_n),
    .bus_in(bus_in),
    .write_protect(write_protect),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .status(status)
);

// ### test/bus_master_model.sv
// two-wire bus master model, paced by the system clock
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    // quarter bit, about 120 ns; keeps data edges far from clock edges
    localparam int TICK = 12;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic tick();
        repeat (TICK) @(posedge clk);
    endtask
    // from idle or from clock low, so it also serves as repeated start
    task automatic start();
        sda <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda <= 1'b0;
        tick();
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick();
        sda <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda <= 1'b1;
        tick();
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick();
        sda <= b;
        tick();
        scl <= 1'b1;
        tick();
        @(negedge clk) r = sda_line;
        tick();
        scl <= 1'b0;
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // more low: withhold the acknowledge so a stop may follow
    task automatic rx(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!more, r);
    endtask
endmodule

// ### test/tb.sv
// self-checking bench: page writes, polling, reads and refusals
`timescale 1ns/1ps
module tb;
    import eeprom_slave_pkg::*;
    // slave address: arbitrary value
    localparam logic [DEV_ADDR_W-1:0] ADDR = 7'h2a;
    localparam int unsigned           PC   = 1000;
    logic    clk;
    logic    rst_n;
    logic    write_protect;
    logic    sda_o;
    logic    sda_oe;
    logic    scl;
    logic    sda_m;
    logic    r;
    logic    [7:0] d;
    bus_in_t bus_in;
    status_t status;
    int      error_cnt;
    int      checks;
    int      seed;
    int      ptr;
    int      l;
    int      mem [256];
    assign bus_in = {scl, sda_m & ~sda_oe};
    eeprom_slave #(.DEV_ADDR(ADDR), .PROG_CYCLES(PC)) i_eeprom_slave (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .bus_in(bus_in), .write_protect(write_protect),
        .sda_o(sda_o), .sda_oe(sda_oe), .status(status));
    bus_master_model m (.clk(clk), .sda_line(bus_in.sda), .scl(scl), .sda(sda_m));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic head(input logic rw, input logic exp);
        m.start();
        m.tx({ADDR, rw}, r);
        chk({7'h0, r}, {7'h0, exp});
        chk({7'h0, status.selected}, {7'h0, exp});
        chk({7'h0, status.read_mode}, {7'h0, rw});
    endtask
    task automatic wr(input int loc, input int n, input logic stop);
        int p;
        p = loc;
        head(1'b0, 1'b1);
        m.tx(8'(loc), r);
        chk({7'h0, r}, 8'h01);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            m.tx(d, r);
            chk({7'h0, r}, 8'h01);
            if (stop && !write_protect) mem[p] = d;
            p = (p & 8'hf8) | ((p + 1) & 7);
        end
        ptr = p;
        if (stop) m.stop();
    endtask
    // negative loc: current location read
    task automatic rd(input int loc, input int n);
        if (loc >= 0) begin
            head(1'b0, 1'b1);
            m.tx(8'(loc), r);
            chk({7'h0, r}, 8'h01);
            ptr = loc;
        end
        head(1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.rx(i < n - 1, d);
            chk(d, 8'(mem[ptr]));
            ptr = (ptr + 1) % 256;
        end
        m.stop();
    endtask
    // first attempt lands inside the commit and must be refused
    task automatic poll();
        int k;
        k = 0;
        r = 1'b0;
        while (!r && k < 20) begin
            m.start();
            m.tx({ADDR, 1'b1}, r);
            if (k == 0) chk({7'h0, r}, 8'h00);
            if (r) begin
                m.rx(1'b0, d);
                chk(d, 8'(mem[ptr]));
                ptr = (ptr + 1) % 256;
            end
            m.stop();
            k++;
        end
        chk({7'h0, r}, 8'h01);
        // polling bound used up: stop here rather than run on
        if (!r) print_verdict();
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        seed = 44;
        error_cnt = 0;
        checks = 0;
        rst_n = 1'b0;
        write_protect = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        m.start();
        m.tx({ADDR ^ 7'h01, 1'b0}, r);
        chk({7'h0, r}, 8'h00);
        chk({7'h0, status.selected}, 8'h00);
        m.stop();
        wr(6, 10, 1'b1);
        poll();
        wr(8'hf8, 8, 1'b1);
        poll();
        rd(8'hfe, 4);
        rd(-1, 1);
        wr(3, 2, 1'b0);
        rd(3, 1);
        repeat (20) @(posedge clk);
        // look between edges so the flop has settled
        @(negedge clk);
        chk({7'h0, status.prog_busy}, 8'h00);
        @(posedge clk);
        write_protect <= 1'b1;
        wr(0, 1, 1'b1);
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk({7'h0, status.prog_busy}, 8'h00);
        @(posedge clk);
        write_protect <= 1'b0;
        rd(0, 1);
        for (int i = 0; i < 3; i++) begin
            // 0..5 keeps the follow-up reads inside the written page
            l = ($random(seed) & 7) % 6;
            wr(l, 1, 1'b1);
            poll();
            rd(-1, 1);
            rd(l, 1);
        end
        print_verdict();
    end
endmodule
